// ==== rtl/uaau_core.sv ====
`timescale 1ns/10ps
// Function
// - With condition on, subtract-with-borrow stores A minus B minus carry into C.
// - Subtract-with-borrow sets carry on a borrow, clears it otherwise.
// - Subtract-with-borrow output is on only on signed overflow or underflow.
// - Unsigned multiply stores the 32-bit product, high in C+1, output on.
// - Unsigned divide stores quotient in C, remainder in C+1, output on if B nonzero.
// - Zero divisor in either divide skips work, output off, error flag set.
// - Error flag stays set until an explicit clear command or a flags register write with the error bit set.
// - With the index register as divide destination, the remainder is discarded.
// - Long divide splits the 32-bit dividend by B into quotient C, remainder C+1.
// - Long divide quotient above 65535 stores 65535 and 0, sets error, output on.
module uaau_core
  import uaau_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic cond_i,
  input wire uaau_op_t op_i,
  input wire logic [WORD_W-1:0] a_lo_i,
  input wire logic [WORD_W-1:0] a_hi_i,
  input wire logic [WORD_W-1:0] b_i,
  input wire logic dest_index_i,
  output logic ready_o,
  output logic done_o,
  output logic out_cond_o,
  output logic [WORD_W-1:0] c_lo_o,
  output logic [WORD_W-1:0] c_hi_o,
  output logic wr_c_lo_o,
  output logic wr_c_hi_o,
  output logic carry_borrow_flag_o,
  output logic instruction_error_flag_o,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [REG_DW-1:0] reg_rdata_o,
  output logic irq_o
);

  uaau_state_t state_q;
  logic carry_q;
  logic error_q;
  logic done_q;
  logic out_q;
  logic [WORD_W-1:0] c_lo_q;
  logic [WORD_W-1:0] c_hi_q;
  logic wr_lo_q;
  logic wr_hi_q;
  logic keep_rem_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [REG_DW-1:0] rdata_q;
  logic [REG_DW-1:0] exec_cnt_q;

  logic take;
  logic run;
  logic is_div;
  logic div_zero;
  logic div_ovf;
  logic div_start;
  logic div_done;
  logic [WORD_W-1:0] div_quo;
  logic [WORD_W-1:0] div_rem;
  logic [WORD_W-1:0] div_hi;
  logic [WORD_W:0] sub_u;
  logic [WORD_W+1:0] sub_s;
  logic sub_ovf;
  logic [2*WORD_W-1:0] product;
  logic wr_flags;
  logic wr_irq;
  logic error_set;
  logic error_clr;
  logic [IRQ_W-1:0] irq_events;

  assign ready_o = (state_q == ST_IDLE);
  assign take = req_i && ready_o;
  assign run = take && cond_i;
  assign is_div = (op_i == OP_UDIV) || (op_i == OP_LDIV);
  assign div_zero = (b_i == 16'h0000);
  assign div_hi = (op_i == OP_LDIV) ? a_hi_i : 16'h0000;
  assign div_ovf = (div_hi >= b_i);
  assign div_start = run && is_div && !div_zero && !div_ovf;

  // The unsigned difference yields the borrow, the signed one the range check.
  assign sub_u = {1'b0, a_lo_i} - {1'b0, b_i} - {16'h0000, carry_q};
  assign sub_s = {{2{a_lo_i[WORD_W-1]}}, a_lo_i} - {{2{b_i[WORD_W-1]}}, b_i}
               - {17'h00000, carry_q};
  assign sub_ovf = (sub_s[WORD_W+1:WORD_W-1] != 3'b000)
                && (sub_s[WORD_W+1:WORD_W-1] != 3'b111);
  assign product = a_lo_i * b_i;

  uaau_divider u_divider (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(div_start),
    .dividend_hi_i(div_hi),
    .dividend_lo_i(a_lo_i),
    .divisor_i(b_i),
    .done_o(div_done),
    .quotient_o(div_quo),
    .remainder_o(div_rem)
  );

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      keep_rem_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (div_start) begin
            state_q <= ST_DIV;
            keep_rem_q <= !dest_index_i;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Results and the output condition are presented together with done.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
      out_q <= 1'b0;
      c_lo_q <= 16'h0000;
      c_hi_q <= 16'h0000;
      wr_lo_q <= 1'b0;
      wr_hi_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      wr_lo_q <= 1'b0;
      wr_hi_q <= 1'b0;
      if (state_q == ST_DIV && div_done) begin
        done_q <= 1'b1;
        out_q <= 1'b1;
        c_lo_q <= div_quo;
        c_hi_q <= div_rem;
        wr_lo_q <= 1'b1;
        wr_hi_q <= keep_rem_q;
      end else if (take && !div_start) begin
        done_q <= 1'b1;
        out_q <= 1'b0;
        if (cond_i) begin
          case (op_i)
            OP_SUBC: begin
              c_lo_q <= sub_u[WORD_W-1:0];
              wr_lo_q <= 1'b1;
              out_q <= sub_ovf;
            end
            OP_UMUL: begin
              c_lo_q <= product[WORD_W-1:0];
              c_hi_q <= product[2*WORD_W-1:WORD_W];
              wr_lo_q <= 1'b1;
              wr_hi_q <= 1'b1;
              out_q <= 1'b1;
            end
            OP_UDIV, OP_LDIV: begin
              if (!div_zero) begin
                c_lo_q <= LIMIT_QUOTIENT;
                c_hi_q <= LIMIT_REMAINDER;
                wr_lo_q <= 1'b1;
                wr_hi_q <= !dest_index_i;
                out_q <= 1'b1;
              end
            end
            default: begin
              out_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Carry follows the subtraction; a clear by command or register is otherwise honoured.
  assign wr_flags = reg_wr_i && (reg_addr_i == OFS_FLAGS);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      carry_q <= 1'b0;
    end else if (run && op_i == OP_SUBC) begin
      carry_q <= sub_u[WORD_W];
    end else if (run && op_i == OP_CLEAR_CARRY) begin
      carry_q <= 1'b0;
    end else if (wr_flags) begin
      carry_q <= reg_wdata_i[FLAG_CARRY_BIT];
    end
  end

  // A new error wins over a clear in the same cycle.
  assign error_set = run && is_div && (div_zero || div_ovf);
  assign error_clr = (run && op_i == OP_CLEAR_ERROR)
                  || (wr_flags && reg_wdata_i[FLAG_ERROR_BIT]);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      error_q <= 1'b0;
    end else if (error_set) begin
      error_q <= 1'b1;
    end else if (error_clr) begin
      error_q <= 1'b0;
    end
  end

  assign irq_events = {error_set, done_q && out_q, done_q};
  assign wr_irq = reg_wr_i && (reg_addr_i == OFS_IRQ_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_irq && reg_wdata_i[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
      irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      exec_cnt_q <= 32'h00000000;
    end else if (done_q && (wr_lo_q || out_q)) begin
      exec_cnt_q <= exec_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_FLAGS: rdata_q <= {30'h00000000, error_q, carry_q};
        OFS_IRQ_STATUS: rdata_q <= {29'h00000000, irq_stat_q};
        OFS_IRQ_MASK: rdata_q <= {29'h00000000, irq_mask_q};
        OFS_LAST_RESULT: rdata_q <= {c_hi_q, c_lo_q};
        OFS_STATUS: rdata_q <= {30'h00000000, out_q, !ready_o};
        OFS_EXEC_COUNT: rdata_q <= exec_cnt_q;
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign done_o = done_q;
  assign out_cond_o = out_q;
  assign c_lo_o = c_lo_q;
  assign c_hi_o = c_hi_q;
  assign wr_c_lo_o = wr_lo_q;
  assign wr_c_hi_o = wr_hi_q;
  assign carry_borrow_flag_o = carry_q;
  assign instruction_error_flag_o = error_q;
  assign reg_rdata_o = rdata_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule

// ==== rtl/uaau_divider.sv ====
`timescale 1ns/10ps
module uaau_divider
  import uaau_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [WORD_W-1:0] dividend_hi_i,
  input wire logic [WORD_W-1:0] dividend_lo_i,
  input wire logic [WORD_W-1:0] divisor_i,
  output logic done_o,
  output logic [WORD_W-1:0] quotient_o,
  output logic [WORD_W-1:0] remainder_o
);

  // The high word must be below the divisor, so sixteen steps always fit.
  uaau_div_state_t state_q;
  logic [3:0] step_q;
  logic [WORD_W-1:0] rem_q;
  logic [WORD_W-1:0] quo_q;
  logic [WORD_W-1:0] div_q;
  logic done_q;
  logic [WORD_W:0] trial;
  logic [WORD_W:0] diff;
  logic fits;

  assign trial = {rem_q, quo_q[WORD_W-1]};
  assign diff = trial - {1'b0, div_q};
  assign fits = (trial >= {1'b0, div_q});

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= DV_IDLE;
      step_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        DV_IDLE: begin
          if (start_i) begin
            state_q <= DV_RUN;
            step_q <= 4'h0;
          end
        end
        DV_RUN: begin
          step_q <= step_q + 4'h1;
          if (step_q == DIV_LAST_STEP) begin
            state_q <= DV_IDLE;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= DV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rem_q <= 16'h0000;
      quo_q <= 16'h0000;
      div_q <= 16'h0000;
    end else if (state_q == DV_IDLE && start_i) begin
      rem_q <= dividend_hi_i;
      quo_q <= dividend_lo_i;
      div_q <= divisor_i;
    end else if (state_q == DV_RUN) begin
      rem_q <= fits ? diff[WORD_W-1:0] : trial[WORD_W-1:0];
      quo_q <= {quo_q[WORD_W-2:0], fits};
    end
  end

  assign done_o = done_q;
  assign quotient_o = quo_q;
  assign remainder_o = rem_q;

endmodule

// ==== shared/uaau_pkg.sv ====
package uaau_pkg;

  typedef enum logic [2:0] {
    OP_SUBC = 3'b000,
    OP_UMUL = 3'b001,
    OP_UDIV = 3'b010,
    OP_LDIV = 3'b011,
    OP_CLEAR_CARRY = 3'b100,
    OP_CLEAR_ERROR = 3'b101
  } uaau_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DIV = 1'b1
  } uaau_state_t;

  typedef enum logic [0:0] {
    DV_IDLE = 1'b0,
    DV_RUN = 1'b1
  } uaau_div_state_t;

  localparam int WORD_W = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  localparam logic [REG_AW-1:0] OFS_FLAGS = 8'h00;
  localparam logic [REG_AW-1:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [REG_AW-1:0] OFS_LAST_RESULT = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [REG_AW-1:0] OFS_EXEC_COUNT = 8'h14;

  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_ERROR_BIT = 1;

  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OUT_BIT = 1;
  localparam int IRQ_ERROR_BIT = 2;
  localparam int IRQ_W = 3;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OUT_BIT = 1;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [WORD_W-1:0] LIMIT_QUOTIENT = 16'hffff;
  localparam logic [WORD_W-1:0] LIMIT_REMAINDER = 16'h0000;
  localparam logic [3:0] DIV_LAST_STEP = 4'hf;

endpackage

// ==== sim/tb_uaau_core.sv ====
`timescale 1ns/10ps
module tb_uaau_core import uaau_pkg::*;;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i, cond_i, dest_index_i, ready_o, done_o, out_cond_o, wr_c_lo_o, wr_c_hi_o;
  logic carry_borrow_flag_o, instruction_error_flag_o, irq_o;
  uaau_op_t op_i;
  logic [15:0] a_lo_i, a_hi_i, b_i, c_lo_o, c_hi_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  uaau_core uut (.*);
  uaau_seq_model seq (.mclk_i(mclk_i), .ready_i(ready_o), .done_i(done_o), .req_o(req_i),
    .cond_o(cond_i), .op_o(op_i), .a_lo_o(a_lo_i), .a_hi_o(a_hi_i), .b_o(b_i),
    .dest_index_o(dest_index_i));
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input uaau_op_t o, input logic c, input logic [31:0] a, input logic [15:0] b,
                    input logic k, input logic [31:0] ec, input logic [4:0] ef);
    seq.issue(o, c, a, b, k);
    chk(32'(done_o), 32'h1);
    chk({c_hi_o, c_lo_o}, ec);
    chk(32'({wr_c_lo_o, wr_c_hi_o, out_cond_o, carry_borrow_flag_o, instruction_error_flag_o}),
        32'(ef));
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic t_sub();
    seq.issue(OP_CLEAR_CARRY, 1'b1, 32'h0, 16'h0, 1'b0);
    op(OP_SUBC, 1'b1, 32'h0, 16'h1, 1'b0, 32'h0000ffff, 5'b10010);
    op(OP_SUBC, 1'b1, 32'h1, 16'h0, 1'b0, 32'h0, 5'b10000);
    op(OP_SUBC, 1'b1, 32'h8000, 16'h1, 1'b0, 32'h7fff, 5'b10100);
    op(OP_SUBC, 1'b1, 32'h7fff, 16'hffff, 1'b0, 32'h8000, 5'b10110);
    op(OP_SUBC, 1'b0, 32'h5, 16'h1, 1'b0, 32'h8000, 5'b00010);
    $display("subtract test done");
  endtask
  task automatic t_mul();
    op(OP_UMUL, 1'b1, 32'hcd14, 16'h1e, 1'b0, 32'h00180858, 5'b11110);
    op(OP_UMUL, 1'b1, 32'hffff, 16'hffff, 1'b0, 32'hfffe0001, 5'b11110);
    op(OP_UMUL, 1'b0, 32'h3, 16'h3, 1'b0, 32'hfffe0001, 5'b00010);
    $display("multiply test done");
  endtask
  task automatic t_div();
    op(OP_UDIV, 1'b1, 32'hd431, 16'h012c, 1'b0, 32'h001500b5, 5'b11110);
    op(OP_UDIV, 1'b1, 32'hd431, 16'h012c, 1'b1, 32'h001500b5, 5'b10110);
    op(OP_UDIV, 1'b1, 32'h7, 16'h0, 1'b0, 32'h001500b5, 5'b00011);
    op(OP_UDIV, 1'b1, 32'h7, 16'h2, 1'b0, 32'h00010003, 5'b11111);
    seq.issue(OP_CLEAR_ERROR, 1'b1, 32'h0, 16'h0, 1'b0);
    chk(32'(instruction_error_flag_o), 32'h0);
    $display("divide test done");
  endtask
  task automatic t_ldiv();
    op(OP_LDIV, 1'b1, 32'h000511e1, 16'h0fa0, 1'b0, 32'h01010053, 5'b11110);
    op(OP_LDIV, 1'b1, 32'h00050000, 16'h5, 1'b0, 32'h0000ffff, 5'b11111);
    op(OP_LDIV, 1'b1, 32'h00050000, 16'h0, 1'b0, 32'h0000ffff, 5'b00011);
    seq.issue(OP_CLEAR_ERROR, 1'b1, 32'h0, 16'h0, 1'b0);
    $display("long divide test done");
  endtask
  task automatic t_irq();
    rd(OFS_FLAGS, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    chk(32'(irq_o), 32'h0);
    op(OP_SUBC, 1'b1, 32'h2, 16'h1, 1'b0, 32'h0, 5'b10000);
    @(negedge mclk_i);
    chk(32'(irq_o), 32'h1);
    rd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    chk(32'(irq_o), 32'h0);
    rd(8'hfc, 32'h0);
    $display("register test done");
  endtask
  task automatic t_regs();
    rd(OFS_EXEC_COUNT, 32'hc);
    rd(OFS_IRQ_MASK, 32'h1);
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS, 32'h1);
    op(uaau_op_t'(3'h6), 1'b1, 32'h9, 16'h9, 1'b0, 32'h0, 5'b00010);
    op(OP_UMUL, 1'b1, 32'h1234, 16'h2, 1'b0, 32'h00002468, 5'b11110);
    rd(OFS_LAST_RESULT, 32'h00002468);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_IRQ_STATUS, 32'h3);
    op(OP_UDIV, 1'b1, 32'h4, 16'h0, 1'b0, 32'h00002468, 5'b00011);
    wr(OFS_IRQ_MASK, 32'h4);
    chk(32'(irq_o), 32'h1);
    rd(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_FLAGS, 32'h2);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h4);
    chk(32'(irq_o), 32'h0);
    rd(OFS_EXEC_COUNT, 32'hd);
    $display("register map test done");
  endtask
  task automatic t_reset();
    wr(OFS_FLAGS, 32'h1);
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(negedge mclk_i);
    chk(32'({ready_o, done_o, out_cond_o, carry_borrow_flag_o, instruction_error_flag_o, irq_o}),
        32'h20);
    chk({c_hi_o, c_lo_o}, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_EXEC_COUNT, 32'h0);
    op(OP_SUBC, 1'b1, 32'h3, 16'h1, 1'b0, 32'h2, 5'b10000);
    $display("reset test done");
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_sub();
    t_mul();
    t_div();
    t_ldiv();
    t_irq();
    t_regs();
    t_reset();
    results();
  end
endmodule

// ==== sim/uaau_core_assertions.sv ====
`timescale 1ns/10ps
module uaau_core_assertions
  import uaau_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic cond_i,
  input wire uaau_op_t op_i,
  input wire logic [15:0] a_lo_i,
  input wire logic [15:0] a_hi_i,
  input wire logic [15:0] b_i,
  input wire logic dest_index_i,
  input wire logic reg_wr_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic out_cond_o,
  input wire logic [15:0] c_lo_o,
  input wire logic [15:0] c_hi_o,
  input wire logic wr_c_lo_o,
  input wire logic wr_c_hi_o,
  input wire logic carry_borrow_flag_o,
  input wire logic instruction_error_flag_o
);
  logic [16:0] u_q;
  logic v_q;
  logic [31:0] m_q;
  wire logic go_w = req_i && ready_o && cond_i && !reg_wr_i;
  wire logic [16:0] u_w = {1'b0, a_lo_i} - {1'b0, b_i} - 17'(carry_borrow_flag_o);
  wire logic [16:0] s_w = {a_lo_i[15], a_lo_i} - {b_i[15], b_i} - 17'(carry_borrow_flag_o);
  always_ff @(posedge mclk_i) begin
    u_q <= u_w;
    v_q <= s_w[16] ^ s_w[15];
    m_q <= a_lo_i * b_i;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence sub_go; go_w && op_i == OP_SUBC; endsequence
  sequence udiv_go; go_w && op_i == OP_UDIV && b_i != 16'h0; endsequence
  sequence ldiv_go; go_w && op_i == OP_LDIV && b_i != 16'h0 && a_hi_i < b_i; endsequence
  sequence busy17; !ready_o [*8] ##1 !ready_o [*8] ##1 !ready_o; endsequence
  cond_off_a: assert property (req_i && ready_o && !cond_i && !reg_wr_i |=> done_o
    && !out_cond_o && !wr_c_lo_o && !wr_c_hi_o && $stable(carry_borrow_flag_o)
    && $stable(instruction_error_flag_o)) else $error("idle op changed state");
  sub_diff_a: assert property (sub_go |=> done_o && wr_c_lo_o && c_lo_o == u_q[15:0])
    else $error("difference wrong");
  sub_borrow_a: assert property (sub_go |=> carry_borrow_flag_o == u_q[16])
    else $error("borrow wrong");
  sub_ovf_a: assert property (sub_go |=> out_cond_o == v_q)
    else $error("overflow output wrong");
  mul_prod_a: assert property (go_w && op_i == OP_UMUL |=> {c_hi_o, c_lo_o} == m_q
    && out_cond_o && wr_c_lo_o && wr_c_hi_o) else $error("product wrong");
  udiv_res_a: assert property (udiv_go |=> busy17 ##1 done_o && out_cond_o
    && c_lo_o == $past(a_lo_i, 18) / $past(b_i, 18) && wr_c_hi_o == !$past(dest_index_i, 18)
    && (!wr_c_hi_o || c_hi_o == $past(a_lo_i, 18) % $past(b_i, 18)))
    else $error("divide wrong");
  div_zero_a: assert property (go_w && op_i inside {OP_UDIV, OP_LDIV} && b_i == 16'h0
    |=> done_o && !out_cond_o && !wr_c_lo_o && !wr_c_hi_o && instruction_error_flag_o)
    else $error("zero divisor not refused");
  err_hold_a: assert property (instruction_error_flag_o && !reg_wr_i
    && !(req_i && ready_o && op_i == OP_CLEAR_ERROR) |=> instruction_error_flag_o)
    else $error("error flag dropped");
  ldiv_res_a: assert property (ldiv_go |=> busy17 ##1 done_o && out_cond_o
    && c_lo_o == {$past(a_hi_i, 18), $past(a_lo_i, 18)} / $past(b_i, 18)
    && (!wr_c_hi_o || c_hi_o == {$past(a_hi_i, 18), $past(a_lo_i, 18)} % $past(b_i, 18)))
    else $error("long divide wrong");
  ldiv_clamp_a: assert property (go_w && op_i == OP_LDIV && b_i != 0 && a_hi_i >= b_i
    |=> done_o && out_cond_o && c_lo_o == LIMIT_QUOTIENT && instruction_error_flag_o
    && (!wr_c_hi_o || c_hi_o == LIMIT_REMAINDER)) else $error("quotient not clamped");
endmodule
bind uaau_core uaau_core_assertions chk_i (.*);

// ==== sim/uaau_seq_model.sv ====
`timescale 1ns/10ps
module uaau_seq_model
  import uaau_pkg::*;
(
  input wire logic mclk_i,
  input wire logic ready_i,
  input wire logic done_i,
  output logic req_o,
  output logic cond_o,
  output uaau_op_t op_o,
  output logic [15:0] a_lo_o,
  output logic [15:0] a_hi_o,
  output logic [15:0] b_o,
  output logic dest_index_o
);
  initial begin
    req_o = 1'b0;
    cond_o = 1'b0;
    op_o = OP_SUBC;
    a_lo_o = 16'h0;
    a_hi_o = 16'h0;
    b_o = 16'h0;
    dest_index_o = 1'b0;
  end
  task automatic issue(input uaau_op_t o, input logic c, input logic [31:0] a,
                       input logic [15:0] b, input logic k);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (ready_i !== 1'b1) @(negedge mclk_i);
    @(posedge mclk_i);
    req_o <= 1'b1;
    cond_o <= c;
    op_o <= o;
    a_lo_o <= a[15:0];
    a_hi_o <= a[31:16];
    b_o <= b;
    dest_index_o <= k;
    @(posedge mclk_i);
    req_o <= 1'b0;
    cond_o <= ~c;
    a_lo_o <= ~a[15:0];
    a_hi_o <= ~a[31:16];
    b_o <= ~b;
    @(negedge mclk_i);
    while (done_i !== 1'b1 && n < 30) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
endmodule
